/* File: design/gri_gauge_dev.sv */
// gauge reset, initial sequence, start-up register file and sampling pacer
`timescale 1ns/1ps
module gri_gauge_dev
  import gri_pkg::*;
#(
  parameter int INIT_CYCLES   = gri_pkg::INIT_SEQ_CYC,
  parameter int SAMPLE_FAST   = gri_pkg::SAMPLE_FAST_CYC,
  parameter int SAMPLE_SLOW   = gri_pkg::SAMPLE_SLOW_CYC
)(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  gri_link_if.dev          link,
  input  wire logic        battery_insert_i,
  input  wire logic [15:0] cell_voltage_i,
  input  wire logic [15:0] cell_current_i,
  input  wire logic        discharging_i,
  input  wire logic        nvm_we_i,
  input  wire logic [3:0]  nvm_idx_i,
  input  wire logic [15:0] nvm_wdata_i,
  input  wire logic        nvm_erase_i,
  output logic             in_reset_o,
  output logic             gauging_o,
  output logic             sample_o
);
  import gri_pkg::*;

  typedef enum logic [1:0] {ST_RESET, ST_INIT, ST_SLEEP, ST_OPERATE} gri_dev_state_t;

  gri_dev_state_t state_q;
  logic [31:0]    init_cnt_q;
  logic [15:0]    nvm_mem_q [CFG_NUM];
  logic           nvm_ok_q  [CFG_NUM];
  logic [15:0]    cfg_q     [CFG_NUM];
  logic           cfg_set_q [CFG_NUM];
  logic           initialized_q;
  logic           take;
  logic           cfg_hit   [CFG_NUM];
  logic           configured;
  logic [15:0]    rdata_d;
  logic [31:0]    samp_cnt_q;
  logic [15:0]    last_cur_q;
  logic [15:0]    cur_diff;
  logic           fast_q;
  logic           reset_cause;

  // ----------------------------------------------------------------
  // reset and initial sequence
  // ----------------------------------------------------------------
  assign reset_cause = battery_insert_i | ~link.external_reset_low_in;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_q    <= ST_RESET;
      init_cnt_q <= '0;
    end
    else if (reset_cause)
    begin
      state_q    <= ST_RESET;
      init_cnt_q <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_RESET:
        begin
          // insertion reset lasts until the cell climbs past the release level
          if (cell_voltage_i > RESET_RELEASE_VOLTAGE_MV)
            state_q <= ST_INIT;
        end
        ST_INIT:
        begin
          init_cnt_q <= init_cnt_q + 32'h1;
          if (init_cnt_q == 32'(INIT_CYCLES - 1))
            state_q <= ST_SLEEP;
        end
        ST_SLEEP:
        begin
          if (configured)
            state_q <= ST_OPERATE;
        end
        ST_OPERATE:
        begin
          if (!configured)
            state_q <= ST_SLEEP;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // non-volatile store, programmed from the user side
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < CFG_NUM; i++)
    begin : g_nvm
      always_ff @(posedge clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          nvm_mem_q[i] <= CFG_RESET_VAL;
          nvm_ok_q[i]  <= 1'b0;
        end
        else if (nvm_erase_i)
          nvm_ok_q[i] <= 1'b0;
        else if (nvm_we_i && nvm_idx_i == 4'(i))
        begin
          nvm_mem_q[i] <= nvm_wdata_i;
          nvm_ok_q[i]  <= 1'b1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // start-up configuration registers
  // ----------------------------------------------------------------
  // accesses only taken once the sequence has reached sleep
  assign take = link.req && !link.ack && !reset_cause
                && (state_q == ST_SLEEP || state_q == ST_OPERATE);

  generate
    for (genvar i = 0; i < CFG_NUM; i++)
    begin : g_cfg
      assign cfg_hit[i] = (link.addr == CFG_CODE[i]);
      always_ff @(posedge clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          cfg_q[i]     <= CFG_RESET_VAL;
          cfg_set_q[i] <= 1'b0;
        end
        else if (state_q == ST_RESET)
        begin
          cfg_q[i]     <= CFG_RESET_VAL;
          cfg_set_q[i] <= 1'b0;
        end
        else if (state_q == ST_INIT && init_cnt_q == 32'h0)
        begin
          // unprogrammed entries keep their fixed default
          cfg_q[i]     <= nvm_ok_q[i] ? nvm_mem_q[i] : CFG_RESET_VAL;
          cfg_set_q[i] <= nvm_ok_q[i];
        end
        else if (take && link.wr && cfg_hit[i])
        begin
          cfg_q[i]     <= link.wdata;
          cfg_set_q[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // thermistor mode also needs the beta and the source select
  assign configured = cfg_set_q[IDX_APA] && cfg_set_q[IDX_PARAM] && cfg_set_q[IDX_PMODE]
                      && cfg_q[IDX_PMODE] == PMODE_OPERATE
                      && (cfg_q[IDX_TSRC] != TSRC_THERMISTOR
                          || (cfg_set_q[IDX_BETA] && cfg_set_q[IDX_TSRC]));

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      initialized_q <= 1'b1;
    else if (state_q == ST_INIT)
      initialized_q <= 1'b1;
    else if (take && link.wr && link.addr == CMD_BATTERY_STATUS)
      initialized_q <= link.wdata[ST_INITIALIZED_BIT];
  end

  // ----------------------------------------------------------------
  // link answer
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_d = 16'h0000;
    for (int i = 0; i < CFG_NUM; i++)
    begin
      if (cfg_hit[i])
        rdata_d = cfg_q[i];
    end
    if (link.addr == CMD_BATTERY_STATUS)
    begin
      rdata_d[ST_INITIALIZED_BIT] = initialized_q;
      rdata_d[ST_DISCHARGING_BIT] = discharging_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      link.ack   <= 1'b0;
      link.rdata <= 16'h0000;
      link.ready <= 1'b0;
    end
    else
    begin
      link.ack   <= take;
      link.ready <= (state_q == ST_SLEEP || state_q == ST_OPERATE) && !reset_cause;
      if (take && !link.wr)
        link.rdata <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // adaptive sampling pacer
  // ----------------------------------------------------------------
  assign cur_diff = (cell_current_i > last_cur_q) ? cell_current_i - last_cur_q
                                                  : last_cur_q - cell_current_i;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      samp_cnt_q <= '0;
      last_cur_q <= 16'h0000;
      fast_q     <= 1'b1;
      sample_o   <= 1'b0;
    end
    else if (state_q != ST_OPERATE)
    begin
      samp_cnt_q <= '0;
      fast_q     <= 1'b1;
      sample_o   <= 1'b0;
    end
    else
    begin
      sample_o <= 1'b0;
      if (samp_cnt_q >= 32'(fast_q ? SAMPLE_FAST - 1 : SAMPLE_SLOW - 1))
      begin
        // steady current stretches the interval to save power
        samp_cnt_q <= '0;
        sample_o   <= 1'b1;
        last_cur_q <= cell_current_i;
        fast_q     <= cur_diff > CURRENT_DELTA_MA;
      end
      else
        samp_cnt_q <= samp_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      in_reset_o <= 1'b1;
      gauging_o  <= 1'b0;
    end
    else
    begin
      in_reset_o <= (state_q == ST_RESET) || reset_cause;
      gauging_o  <= (state_q == ST_OPERATE);
    end
  end
endmodule

/* File: shared/gri_pkg.sv */
// constants shared by the gauge start-up sequencer and its host controller
package gri_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ             = 20_000_000;
  localparam int CLK_PER_US         = CLK_HZ / 1_000_000;
  localparam int INIT_SEQ_TIME_US   = 500;
  localparam int INIT_SEQ_CYC       = INIT_SEQ_TIME_US * CLK_PER_US;
  localparam int SAMPLE_FAST_US     = 100;
  localparam int SAMPLE_FAST_CYC    = SAMPLE_FAST_US * CLK_PER_US;
  localparam int SAMPLE_SLOW_US     = 1000;
  localparam int SAMPLE_SLOW_CYC    = SAMPLE_SLOW_US * CLK_PER_US;
  localparam int HOST_POLL_US       = 50;
  localparam int HOST_POLL_CYC      = HOST_POLL_US * CLK_PER_US;
  // ----------------------------------------------------------------
  // analog thresholds (mV, mA)
  // ----------------------------------------------------------------
  localparam logic [15:0] RESET_RELEASE_VOLTAGE_MV = 16'h0B54;
  localparam logic [15:0] CURRENT_DELTA_MA         = 16'h0032;
  // ----------------------------------------------------------------
  // device command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_THERMISTOR_BETA   = 8'h06;
  localparam logic [7:0] CMD_PROFILE_ADJUST    = 8'h0B;
  localparam logic [7:0] CMD_PROFILE_THERMAL   = 8'h0C;
  localparam logic [7:0] CMD_PROFILE_SELECT    = 8'h12;
  localparam logic [7:0] CMD_LOW_CHARGE_ALARM  = 8'h13;
  localparam logic [7:0] CMD_LOW_VOLT_ALARM    = 8'h14;
  localparam logic [7:0] CMD_POWER_MODE        = 8'h15;
  localparam logic [7:0] CMD_TEMP_SOURCE       = 8'h16;
  localparam logic [7:0] CMD_BATTERY_STATUS    = 8'h19;
  localparam logic [7:0] CMD_TERM_CURRENT      = 8'h1C;
  localparam logic [7:0] CMD_EMPTY_VOLTAGE     = 8'h1D;
  localparam logic [7:0] CMD_EMPTY_EST_OFFSET  = 8'h1E;
  localparam logic [7:0] CMD_HIGH_VOLT_ALARM   = 8'h1F;
  localparam logic [7:0] CMD_LOW_TEMP_ALARM    = 8'h20;
  localparam logic [7:0] CMD_HIGH_TEMP_ALARM   = 8'h21;
  localparam int CFG_NUM = 14;
  localparam logic [7:0] CFG_CODE [CFG_NUM] = '{
    CMD_THERMISTOR_BETA, CMD_PROFILE_ADJUST, CMD_PROFILE_THERMAL, CMD_PROFILE_SELECT,
    CMD_LOW_CHARGE_ALARM, CMD_LOW_VOLT_ALARM, CMD_POWER_MODE, CMD_TEMP_SOURCE,
    CMD_TERM_CURRENT, CMD_EMPTY_VOLTAGE, CMD_EMPTY_EST_OFFSET, CMD_HIGH_VOLT_ALARM,
    CMD_LOW_TEMP_ALARM, CMD_HIGH_TEMP_ALARM};
  localparam int IDX_BETA   = 0;
  localparam int IDX_APA    = 1;
  localparam int IDX_PARAM  = 3;
  localparam int IDX_PMODE  = 6;
  localparam int IDX_TSRC   = 7;
  localparam logic [15:0] CFG_RESET_VAL   = 16'h0000;
  localparam logic [15:0] PMODE_OPERATE   = 16'h0001;
  localparam logic [15:0] TSRC_THERMISTOR = 16'h0001;
  localparam int ST_INITIALIZED_BIT = 7;
  localparam int ST_DISCHARGING_BIT = 6;
  // ----------------------------------------------------------------
  // host controller APB map
  // ----------------------------------------------------------------
  localparam logic [7:0] HOST_CTRL_OFS   = 8'h00;
  localparam logic [7:0] HOST_APA_OFS    = 8'h04;
  localparam logic [7:0] HOST_PARAM_OFS  = 8'h08;
  localparam logic [7:0] HOST_PMODE_OFS  = 8'h0C;
  localparam logic [7:0] HOST_BETA_OFS   = 8'h10;
  localparam logic [7:0] HOST_STATUS_OFS = 8'h14;
  localparam int CTRL_AUTO_BIT  = 0;
  localparam int CTRL_THERM_BIT = 1;
  localparam int CTRL_RESET_BIT = 2;
  localparam logic [2:0]  HOST_CTRL_RESET_VAL = 3'h0;
  localparam logic [15:0] HOST_CFG_RESET_VAL  = 16'h0000;
endpackage

/* File: shared/gri_link_if.sv */
// register link between the gauge and its host
`timescale 1ns/1ps
interface gri_link_if;
  logic        req;
  logic        wr;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        ack;
  logic [15:0] rdata;
  logic        ready;
  logic        external_reset_low_in;

  modport dev  (input req, wr, addr, wdata, external_reset_low_in, output ack, rdata, ready);
  modport host (output req, wr, addr, wdata, external_reset_low_in, input ack, rdata, ready);
endinterface

/* File: design/gri_host_ctl.sv */
// host controller: APB registers, reset pin and configuration flow
`timescale 1ns/1ps
module gri_host_ctl
  import gri_pkg::*;
#(
  parameter int POLL_CYCLES = gri_pkg::HOST_POLL_CYC
)(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  gri_link_if.host         link,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);
  import gri_pkg::*;

  typedef enum logic [2:0] {H_WAIT, H_IDLE, H_POLL, H_STEP, H_ACC} gri_host_state_t;

  gri_host_state_t hst_q;
  logic [2:0]  ctrl_q;
  logic [15:0] apa_q, param_q, pmode_q, beta_q;
  logic [2:0]  step_q;
  logic [31:0] poll_q;
  logic        done_q;
  logic        acc_en;
  logic        mapped;
  logic [31:0] rd_d;
  logic [7:0]  st_addr;
  logic [15:0] st_data;
  logic        st_skip;

  // ----------------------------------------------------------------
  // APB slave, one wait-free access cycle
  // ----------------------------------------------------------------
  assign acc_en = psel_i && penable_i && pready_o;
  assign mapped = paddr_i inside {HOST_CTRL_OFS, HOST_APA_OFS, HOST_PARAM_OFS, HOST_PMODE_OFS,
                                  HOST_BETA_OFS, HOST_STATUS_OFS};

  always_comb
  begin
    rd_d = 32'h0000_0000;
    unique case (paddr_i)
      HOST_CTRL_OFS:   rd_d = {29'h0, ctrl_q};
      HOST_APA_OFS:    rd_d = {16'h0, apa_q};
      HOST_PARAM_OFS:  rd_d = {16'h0, param_q};
      HOST_PMODE_OFS:  rd_d = {16'h0, pmode_q};
      HOST_BETA_OFS:   rd_d = {16'h0, beta_q};
      HOST_STATUS_OFS: rd_d = {29'h0, done_q, hst_q == H_STEP || hst_q == H_ACC, link.ready};
      default:         rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end
    else
    begin
      pready_o  <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !mapped;
      if (psel_i && !penable_i)
        prdata_o <= rd_d;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_q  <= HOST_CTRL_RESET_VAL;
      apa_q   <= HOST_CFG_RESET_VAL;
      param_q <= HOST_CFG_RESET_VAL;
      pmode_q <= HOST_CFG_RESET_VAL;
      beta_q  <= HOST_CFG_RESET_VAL;
    end
    else if (acc_en && pwrite_i)
    begin
      unique case (paddr_i)
        HOST_CTRL_OFS:  ctrl_q  <= pwdata_i[2:0];
        HOST_APA_OFS:   apa_q   <= pwdata_i[15:0];
        HOST_PARAM_OFS: param_q <= pwdata_i[15:0];
        HOST_PMODE_OFS: pmode_q <= pwdata_i[15:0];
        HOST_BETA_OFS:  beta_q  <= pwdata_i[15:0];
        default:        ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // configuration flow: beta, source, profile, parameter, mode, flag
  // ----------------------------------------------------------------
  always_comb
  begin
    st_addr = CMD_BATTERY_STATUS;
    st_data = 16'h0000;
    st_skip = 1'b0;
    unique case (step_q)
      3'h0:
      begin
        st_addr = CMD_THERMISTOR_BETA;
        st_data = beta_q;
        st_skip = !ctrl_q[CTRL_THERM_BIT];
      end
      3'h1:
      begin
        st_addr = CMD_TEMP_SOURCE;
        st_data = ctrl_q[CTRL_THERM_BIT] ? TSRC_THERMISTOR : 16'h0000;
      end
      3'h2:
      begin
        st_addr = CMD_PROFILE_ADJUST;
        st_data = apa_q;
      end
      3'h3:
      begin
        st_addr = CMD_PROFILE_SELECT;
        st_data = param_q;
      end
      3'h4:
      begin
        st_addr = CMD_POWER_MODE;
        st_data = pmode_q;
      end
      default:
      begin
        st_addr = CMD_BATTERY_STATUS;
        st_data = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hst_q      <= H_WAIT;
      step_q     <= 3'h0;
      poll_q     <= '0;
      done_q     <= 1'b0;
      link.req   <= 1'b0;
      link.wr    <= 1'b0;
      link.addr  <= 8'h00;
      link.wdata <= 16'h0000;
      link.external_reset_low_in <= 1'b1;
    end
    else
    begin
      link.external_reset_low_in <= !ctrl_q[CTRL_RESET_BIT];
      if (!link.ready)
      begin
        // device reset or still initialising: back to wait and drop the request
        hst_q    <= H_WAIT;
        link.req <= 1'b0;
      end
      else
      begin
        unique case (hst_q)
          H_WAIT:
          begin
            hst_q  <= H_IDLE;
            poll_q <= '0;
          end
          H_IDLE:
          begin
            poll_q <= poll_q + 32'h1;
            if (poll_q >= 32'(POLL_CYCLES - 1))
            begin
              poll_q     <= '0;
              hst_q      <= H_POLL;
              link.req   <= 1'b1;
              link.wr    <= 1'b0;
              link.addr  <= CMD_BATTERY_STATUS;
            end
          end
          H_POLL:
          begin
            if (link.ack)
            begin
              link.req <= 1'b0;
              step_q   <= 3'h0;
              if (link.rdata[ST_INITIALIZED_BIT])
              begin
                done_q <= 1'b0;
                hst_q  <= ctrl_q[CTRL_AUTO_BIT] ? H_STEP : H_IDLE;
              end
              else
                hst_q <= H_IDLE;
            end
          end
          H_STEP:
          begin
            if (st_skip)
              step_q <= step_q + 3'h1;
            else
            begin
              link.req   <= 1'b1;
              link.wr    <= 1'b1;
              link.addr  <= st_addr;
              link.wdata <= st_data;
              hst_q      <= H_ACC;
            end
          end
          H_ACC:
          begin
            if (link.ack)
            begin
              link.req <= 1'b0;
              step_q   <= step_q + 3'h1;
              if (step_q == 3'h5)
              begin
                done_q <= 1'b1;
                hst_q  <= H_IDLE;
              end
              else
                hst_q <= H_STEP;
            end
          end
          default: hst_q <= H_WAIT;
        endcase
      end
    end
  end
endmodule

/* File: testbench/gri_link_chk.sv */
// link and sequencer checker for the gauge start-up pair
`timescale 1ns/1ps
module gri_link_chk
  import gri_pkg::*;
#(
  parameter int INIT_CYCLES = 20
)(
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        ready,
  input wire logic        ack,
  input wire logic        external_reset_low_in,
  input wire logic        battery_insert_i,
  input wire logic [15:0] cell_voltage_i,
  input wire logic        in_reset_o,
  input wire logic        gauging_o,
  input wire logic        sample_o
);
  // slack both ways: ready is one register behind the state
  localparam int T_LO = INIT_CYCLES - 2;
  localparam int T_HI = INIT_CYCLES + 3;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_insert_forces_reset: assert property (battery_insert_i |=> in_reset_o)
    else $error("insertion left reset state");
  a_low_volt_holds: assert property (in_reset_o && cell_voltage_i <= RESET_RELEASE_VOLTAGE_MV |=> in_reset_o)
    else $error("reset left below release level");
  a_init_time: assert property ($fell(in_reset_o) |-> ##[T_LO:T_HI] $rose(ready))
    else $error("initial sequence length wrong");
  a_gauge_off_reset: assert property (in_reset_o && $past(in_reset_o) |-> !gauging_o)
    else $error("gauging while in reset");
  a_pin_forces_reset: assert property (!external_reset_low_in |=> in_reset_o)
    else $error("low reset pin left reset state");
  a_sample_in_gauge: assert property (sample_o |-> $past(gauging_o))
    else $error("sample outside operation");
  a_ready_not_reset: assert property (in_reset_o |-> !ready)
    else $error("link ready in reset");
  a_init_quiet: assert property ($fell(in_reset_o) |-> !ready [*8])
    else $error("link ready during initial sequence");
  a_ack_not_reset: assert property (ack |-> !$past(in_reset_o))
    else $error("access taken in reset");
endmodule

/* File: testbench/tb_gauge_reset_and_init_loader.sv */
// self-checking bench for the gauge start-up sequencer and its host
`timescale 1ns/1ps
module tb_gauge_reset_and_init_loader;
  import gri_pkg::*;
  localparam int INIT = 20;
  localparam int FAST = 8;
  localparam int SLOW = 32;
  logic        clk_i, rst_b_i, battery_insert_i, nvm_we_i, in_reset_o, gauging_o, sample_o;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [15:0] cell_voltage_i, cell_current_i, nvm_wdata_i;
  logic [3:0]  nvm_idx_i;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          errors, n_tests, n;
  gri_link_if link_if ();
  gri_gauge_dev #(.INIT_CYCLES(INIT), .SAMPLE_FAST(FAST), .SAMPLE_SLOW(SLOW)) gri_gauge_dev_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .link(link_if.dev), .battery_insert_i(battery_insert_i),
    .cell_voltage_i(cell_voltage_i), .cell_current_i(cell_current_i), .discharging_i(1'b0), .nvm_we_i(nvm_we_i),
    .nvm_idx_i(nvm_idx_i), .nvm_wdata_i(nvm_wdata_i), .nvm_erase_i(1'b0), .in_reset_o(in_reset_o),
    .gauging_o(gauging_o), .sample_o(sample_o));
  gri_host_ctl #(.POLL_CYCLES(4)) gri_host_ctl_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .link(link_if.host), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr));
  gri_link_chk #(.INIT_CYCLES(INIT)) gri_link_chk_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ready(link_if.ready), .ack(link_if.ack),
    .external_reset_low_in(link_if.external_reset_low_in), .battery_insert_i(battery_insert_i),
    .cell_voltage_i(cell_voltage_i), .in_reset_o(in_reset_o), .gauging_o(gauging_o), .sample_o(sample_o));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    // values read here are those sampled at this edge
    // no local limit: only the watchdog ends a stuck access
    do
    begin
      @(posedge clk_i);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_link();
    n = 0;
    while (link_if.ready !== 1'b1 && n < 200)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic wait_gauge();
    int k;
    k = 0;
    while (gauging_o !== 1'b1 && k < 600)
    begin
      @(posedge clk_i);
      k++;
    end
  endtask
  task automatic sample_gap();
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (sample_o !== 1'b1 && n < 100);
  endtask
  task automatic nvm_put(input logic [3:0] i, input logic [15:0] v);
    @(posedge clk_i);
    nvm_we_i <= 1'b1;
    nvm_idx_i <= i;
    nvm_wdata_i <= v;
    @(posedge clk_i);
    nvm_we_i <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_power_up();
    apb(1'b0, HOST_CTRL_OFS, '0);
    chk("ctrl reset value", rd, 32'h0000_0000);
    // exactly at the release level must still hold reset
    repeat (40) @(posedge clk_i);
    chk("held at release level", in_reset_o, 1'b1);
    apb(1'b0, HOST_STATUS_OFS, '0);
    chk("link ready in reset", rd[0], 1'b0);
    cell_voltage_i <= RESET_RELEASE_VOLTAGE_MV + 16'h0001;
    wait_link();
    chk("init span", n inside {[INIT:INIT + 6]}, 1'b1);
    chk("no gauging unprogrammed", gauging_o, 1'b0);
    apb(1'b0, HOST_STATUS_OFS, '0);
    chk("link ready after init", rd[0], 1'b1);
    $display("done power up");
  endtask
  task automatic t_host_flow();
    apb(1'b1, HOST_APA_OFS, 32'h0000_0005);
    apb(1'b1, HOST_PARAM_OFS, 32'h0000_0001);
    apb(1'b1, HOST_PMODE_OFS, {16'h0000, PMODE_OPERATE});
    apb(1'b1, HOST_CTRL_OFS, 32'h0000_0001);
    wait_gauge();
    chk("gauging after host flow", gauging_o, 1'b1);
    apb(1'b0, HOST_STATUS_OFS, '0);
    chk("flow done", rd[2], 1'b1);
    // first pulse sees the full step from zero current, so the next gap is short
    sample_gap();
    sample_gap();
    chk("first sample period", n, FAST);
    sample_gap();
    chk("steady current sample period", n, SLOW);
    cell_current_i <= 16'h0200;
    sample_gap();
    chk("slow gap before change seen", n, SLOW);
    sample_gap();
    chk("changed current sample period", n, FAST);
    $display("done host flow");
  endtask
  task automatic t_pin_reset();
    apb(1'b1, HOST_CTRL_OFS, 32'h0000_0005);
    repeat (4) @(posedge clk_i);
    chk("pin reset", in_reset_o, 1'b1);
    chk("gauging dropped", gauging_o, 1'b0);
    apb(1'b1, HOST_CTRL_OFS, 32'h0000_0001);
    wait_link();
    chk("init span after pin", n inside {[INIT:INIT + 8]}, 1'b1);
    // gauging only returns if the flag came back and the host reran its flow
    wait_gauge();
    chk("reconfigured", gauging_o, 1'b1);
    $display("done pin reset");
  endtask
  task automatic t_nvm_alone();
    apb(1'b1, HOST_CTRL_OFS, 32'h0000_0000);
    nvm_put(4'h1, 16'h0005);
    nvm_put(4'h3, 16'h0001);
    nvm_put(4'h6, PMODE_OPERATE);
    @(posedge clk_i);
    battery_insert_i <= 1'b1;
    @(posedge clk_i);
    battery_insert_i <= 1'b0;
    // gauging output lags the state by one register
    repeat (2) @(posedge clk_i);
    chk("insertion reset", in_reset_o, 1'b1);
    chk("gauging cleared", gauging_o, 1'b0);
    wait_link();
    wait_gauge();
    chk("stand-alone gauging", gauging_o, 1'b1);
    $display("done stand-alone");
  endtask
  task automatic t_unmapped();
    apb(1'b0, 8'h18, '0);
    chk("unmapped error", err, 1'b1);
    chk("unmapped data", rd, 32'h0000_0000);
    $display("done unmapped");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    $display("Error watchdog expected finish seen hang");
    end_of_test();
  end
  initial
  begin
    errors = 0;
    n_tests = 0;
    rst_b_i = 1'b0;
    battery_insert_i = 1'b0;
    cell_voltage_i = RESET_RELEASE_VOLTAGE_MV;
    cell_current_i = 16'h0100;
    nvm_we_i = 1'b0;
    nvm_idx_i = 4'h0;
    nvm_wdata_i = 16'h0000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_power_up();
    t_host_flow();
    t_pin_reset();
    t_nvm_alone();
    t_unmapped();
    end_of_test();
  end
endmodule
